/* pkg/i2cdac_pkg.sv */
package i2cdac_pkg;
    // ****************************************
    // Bus framing constants
    // ****************************************
    localparam int BYTE_BITS = 8;                  // Bits per byte on the bus
    localparam int WORD_BITS = 16;                 // Converter register width
    localparam int CODE_BITS = 12;                 // Converter code width
    localparam logic [2:0] LAST_BIT = 3'h7;        // Index of final bit
    localparam logic [6:0] BCAST_ADDR = 7'h48;     // Broadcast address 1001000
    localparam logic [4:0] HS_CODE_TOP = 5'h01;    // Controller code 00001xxx
    localparam logic [6:0] DEF_OWN_ADDR = 7'h0C;   // Default own address
    localparam logic [15:0] WORD_RESET = 16'h0000; // Register at power-up

    // Receiver phases
    typedef enum logic [2:0] {
        I2CDAC_IDLE,   // Waiting for a start
        I2CDAC_ADDR,   // Shifting the address byte in
        I2CDAC_AACK,   // Address acknowledge slot
        I2CDAC_WRX,    // Shifting a write byte in
        I2CDAC_WACK,   // Write-byte acknowledge slot
        I2CDAC_RTX,    // Shifting a read byte out
        I2CDAC_RACK,   // Controller acknowledge slot
        I2CDAC_SKIP    // Ignoring traffic until next start
    } i2cdac_state_t;
endpackage

/* src/i2cdac_target.sv */
`timescale 1ns/1ps
// Behaviour
// - Code is straight binary 0 to 4095
// - Standard and fast speeds behave identically
// - Drive low only; release for one
// - Acknowledge matching address, else release
// - Acknowledge every received write byte
// - Repeated start keeps speed mode
// - Stop is data rise; then idle
// - Seven address bits, direction, then answer
// - Upper then lower byte; update after
// - Consecutive byte pairs are successive words
// - Read sends upper, then lower byte
// - Not-acknowledge high-speed controller code
// - High-speed mode held across repeated starts
// - Stop reverts to standard/fast mode
// - Also answer the broadcast address
// - Register clears to zero at power-up
module i2cdac_target #(
    parameter logic [6:0] OWN_ADDR = i2cdac_pkg::DEF_OWN_ADDR
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,              // Bus clock line level
    input wire logic sda_in,              // Bus data line level
    output logic sda_out,                 // Always low when driving
    output logic sda_oe,                  // High while pulling data low
    output logic [11:0] dac_code,         // Code applied to the converter
    output logic [1:0] dac_mode,          // Word bits 13:12, just above the code
    output logic dac_update,              // Pulse when output updates
    output logic hs_mode                  // High-speed mode active
);
    // ****************************************
    // Input synchronisers and edge detection
    // ****************************************
    logic scl_m, scl_s, scl_d;            // Clock line sync chain
    logic sda_m, sda_s, sda_d;            // Data line sync chain
    i2cdac_pkg::i2cdac_state_t state;     // Protocol phase
    logic [2:0] bit_cnt;                  // Bit index within byte
    logic [7:0] shreg;                    // Byte being shifted
    logic [15:0] word;                    // Converter register
    logic [7:0] upper;                    // Held upper byte
    logic low_byte;                       // Second byte of pair pending
    logic drive;                          // Pulling data low

    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    // Line is sampled only after two flops so glitch-free edges result
    wire start_c = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_c = scl_s & scl_d & ~sda_d & sda_s;
    wire [7:0] rx_byte = {shreg[6:0], sda_s};
    // Address decode looks at the completed byte held in shreg, since
    // the ack slot is entered after the eighth bit has been shifted in
    wire addr_hit = (shreg[7:1] == OWN_ADDR) ||
                    (shreg[7:1] == i2cdac_pkg::BCAST_ADDR);
    wire hs_code = (shreg[7:3] == i2cdac_pkg::HS_CODE_TOP);
    wire last_bit = (bit_cnt == i2cdac_pkg::LAST_BIT);
    wire [15:0] full_word = {upper, shreg};

    // Two-flop synchronisers for both pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
        end else begin
            {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
        end
    end

    // ****************************************
    // Protocol engine
    // ****************************************
    // Speed only tracks the mode flag; timing is the same for 100 and
    // 400 kHz since we oversample the lines
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= i2cdac_pkg::I2CDAC_IDLE;
            bit_cnt <= 3'h0;
            shreg <= 8'h00;
            word <= i2cdac_pkg::WORD_RESET;
            upper <= 8'h00;
            low_byte <= 1'b0;
            drive <= 1'b0;
            dac_update <= 1'b0;
            hs_mode <= 1'b0;
        end else begin
            dac_update <= 1'b0;
            if (stop_c) begin
                // Stop ends everything and drops high speed
                state <= i2cdac_pkg::I2CDAC_IDLE;
                drive <= 1'b0;
                hs_mode <= 1'b0;
            end else if (start_c) begin
                // Start or repeated start; hs_mode kept
                state <= i2cdac_pkg::I2CDAC_ADDR;
                bit_cnt <= 3'h0;
                drive <= 1'b0;
            end else begin
                unique case (state)
                    i2cdac_pkg::I2CDAC_IDLE, i2cdac_pkg::I2CDAC_SKIP: begin
                        drive <= 1'b0;
                    end
                    i2cdac_pkg::I2CDAC_ADDR: begin
                        if (scl_rise) begin
                            shreg <= rx_byte;
                            bit_cnt <= bit_cnt + 3'h1;
                            if (last_bit) begin
                                state <= i2cdac_pkg::I2CDAC_AACK;
                            end
                        end
                    end
                    i2cdac_pkg::I2CDAC_AACK: begin
                        if (scl_fall && !drive) begin
                            // Enter ack slot; hs code is never acked
                            if (!hs_code && addr_hit) begin
                                drive <= 1'b1;
                            end else begin
                                if (hs_code) begin
                                    hs_mode <= 1'b1;
                                end
                                state <= i2cdac_pkg::I2CDAC_SKIP;
                            end
                        end else if (scl_fall) begin
                            drive <= 1'b0;
                            low_byte <= 1'b0;
                            if (shreg[0]) begin
                                state <= i2cdac_pkg::I2CDAC_RTX;
                                drive <= ~word[15];
                                shreg <= word[15:8];
                            end else begin
                                state <= i2cdac_pkg::I2CDAC_WRX;
                            end
                        end
                    end
                    i2cdac_pkg::I2CDAC_WRX: begin
                        if (scl_rise) begin
                            shreg <= rx_byte;
                            bit_cnt <= bit_cnt + 3'h1;
                            if (last_bit) begin
                                state <= i2cdac_pkg::I2CDAC_WACK;
                                if (!low_byte) begin
                                    upper <= rx_byte;
                                end
                            end
                        end
                    end
                    i2cdac_pkg::I2CDAC_WACK: begin
                        if (scl_fall && !drive) begin
                            drive <= 1'b1;
                            if (low_byte) begin
                                word <= full_word;
                                dac_update <= 1'b1;
                            end
                        end else if (scl_fall) begin
                            drive <= 1'b0;
                            low_byte <= ~low_byte;
                            state <= i2cdac_pkg::I2CDAC_WRX;
                        end
                    end
                    i2cdac_pkg::I2CDAC_RTX: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 3'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt == 3'h0) begin
                                // Byte done: release for controller ack
                                drive <= 1'b0;
                                state <= i2cdac_pkg::I2CDAC_RACK;
                            end else begin
                                drive <= ~shreg[i2cdac_pkg::LAST_BIT -
                                                bit_cnt];
                            end
                        end
                    end
                    i2cdac_pkg::I2CDAC_RACK: begin
                        if (scl_rise) begin
                            // Nack ends read; ack after upper sends lower
                            if (sda_s || low_byte) begin
                                state <= i2cdac_pkg::I2CDAC_SKIP;
                            end else begin
                                low_byte <= 1'b1;
                                shreg <= word[7:0];
                            end
                        end else if (scl_fall && low_byte &&
                                     state == i2cdac_pkg::I2CDAC_RACK) begin
                            state <= i2cdac_pkg::I2CDAC_RTX;
                            drive <= ~shreg[7];
                        end
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Outputs, all from flops
    // ****************************************
    // Code is plain binary over the low twelve bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dac_code <= 12'h000;
            dac_mode <= 2'h0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            dac_code <= word[11:0];
            dac_mode <= word[13:12];
            sda_out <= 1'b0;          // Never drive high
            sda_oe <= drive;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    AST_NO_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
        sda_out == 1'b0) else $error("data driven high");
    AST_STOP_HS: assert property (@(posedge clk) disable iff (!rst_n)
        stop_c |=> !hs_mode) else $error("hs kept after stop");
    AST_SKIP_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
        state == i2cdac_pkg::I2CDAC_SKIP |=> ##1 !sda_oe)
        else $error("drove while ignoring");
    AST_UPD_CODE: assert property (@(posedge clk) disable iff (!rst_n)
        dac_update |=> ##1 dac_code == word[11:0])
        else $error("code not updated");
    AST_IDLE_STOP: assert property (@(posedge clk) disable iff (!rst_n)
        stop_c |=> state == i2cdac_pkg::I2CDAC_IDLE)
        else $error("not idle after stop");
    AST_START_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
        start_c && !stop_c |=> state == i2cdac_pkg::I2CDAC_ADDR &&
        hs_mode == $past(hs_mode)) else $error("bad repeated start");
    AST_HS_NACK: assert property (@(posedge clk) disable iff (!rst_n)
        state == i2cdac_pkg::I2CDAC_AACK && scl_fall && !drive && hs_code
        |=> !drive) else $error("hs code acked");
    AST_ADDR_ACK: assert property (@(posedge clk) disable iff (!rst_n)
        state == i2cdac_pkg::I2CDAC_AACK && scl_fall && !drive &&
        addr_hit && !hs_code && !start_c && !stop_c |=> drive)
        else $error("address not acked");
    COV_WRITE: cover property (@(posedge clk) dac_update);
    COV_HS: cover property (@(posedge clk) hs_mode);
    COV_READ: cover property (@(posedge clk)
        state == i2cdac_pkg::I2CDAC_RACK);
endmodule

/* dv/i2cdac_ctl_model.sv */
`timescale 1ns/1ps
// ********************************
// Bus controller model
// ********************************
module i2cdac_ctl_model (
    input wire logic clk,
    input wire logic sda_line,        // Resolved data line
    output logic scl_low,             // High while pulling clock low
    output logic sda_low              // High while pulling data low
);
    // Idle bus: both lines released to the pull-ups
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    // Moves only on falling clk edges, away from device sampling
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Start or repeated start: data falls while clock high
    task automatic start_cond;
        sda_low = 1'b0;
        tick(2);
        scl_low = 1'b0;
        tick(4);
        sda_low = 1'b1;
        tick(4);
        scl_low = 1'b1;
        tick(2);
    endtask

    // Stop: data rises while clock high, then idle
    task automatic stop_cond;
        sda_low = 1'b1;
        tick(2);
        scl_low = 1'b0;
        tick(4);
        sda_low = 1'b0;
        tick(8);
    endtask

    // One 800 ns bit; a one is sent by releasing only
    task automatic one_bit(input logic b, output logic r);
        sda_low = !b;
        tick(2);
        scl_low = 1'b0;
        tick(2);
        r = sda_line;
        tick(2);
        scl_low = 1'b1;
        tick(2);
    endtask

    // Byte MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic ack_bit,
                        output logic [7:0] r, output logic ack_seen);
        for (int i = 7; i >= 0; i--) begin
            one_bit(d[i], r[i]);
        end
        one_bit(ack_bit, ack_seen);
    endtask
endmodule

/* dv/tb_i2cdac_target.sv */
`timescale 1ns/1ps
// ********************************
// Testbench
// ********************************
module tb_i2cdac_target;
    logic clk, rst_n, sda_out, sda_oe, dac_update, hs_mode;
    logic [11:0] dac_code;
    logic [1:0] dac_mode;
    logic scl_low, sda_low, nk;
    logic [7:0] rb;
    int miscompares = 0;
    int total_checks = 0;
    int upd_cnt = 0;
    int hi_cnt = 0;
    // Open-drain lines with pull-ups; nobody drives high
    wire scl = !scl_low;
    wire sda = !(sda_low | (sda_oe & !sda_out));
    wire [15:0] word = {2'h0, dac_mode, dac_code};

    i2cdac_target i2cdac_target_inst (.clk(clk), .rst_n(rst_n),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .dac_code(dac_code), .dac_mode(dac_mode),
        .dac_update(dac_update), .hs_mode(hs_mode));
    i2cdac_ctl_model i2cdac_ctl_model_inst (.clk(clk), .sda_line(sda),
        .scl_low(scl_low), .sda_low(sda_low));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Update pulses are counted so missing or extra ones show; sampled
    // mid-cycle so the edge that launches them is not raced
    always @(negedge clk) begin
        if (dac_update === 1'b1) upd_cnt++;
        // The data pin may only ever be pulled low
        if (sda_out !== 1'b0) hi_cnt++;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic [7:0] d);
        i2cdac_ctl_model_inst.xfer(d, 1'b1, rb, nk);
    endtask
    task automatic rd(input logic last);
        i2cdac_ctl_model_inst.xfer(8'hFF, last, rb, nk);
    endtask
    task automatic go;
        i2cdac_ctl_model_inst.start_cond;
    endtask
    task automatic halt;
        i2cdac_ctl_model_inst.stop_cond;
    endtask

    // Two words back to back, then read back after repeated start
    task automatic t_write_read;
        int u0;
        u0 = upd_cnt;
        go;
        wb({7'h0C, 1'b0});
        chk(16'(nk), 16'h0000);
        wb(8'h3A);
        chk(16'(nk), 16'h0000);
        wb(8'hBC);
        chk(word, 16'h3ABC);
        wb(8'h0F);
        wb(8'hFF);
        chk(word, 16'h0FFF);
        chk(16'(upd_cnt - u0), 16'h0002);
        go;
        wb({7'h0C, 1'b1});
        chk(16'(nk), 16'h0000);
        rd(1'b0);
        chk(16'(rb), 16'h000F);
        rd(1'b1);
        chk(16'(rb), 16'h00FF);
        chk(16'(nk), 16'h0001);
        halt;
        chk(16'(hi_cnt), 16'h0000);
    endtask

    // Foreign address: no acks, no update, line never pulled
    task automatic t_foreign;
        int u0;
        u0 = upd_cnt;
        go;
        wb({7'h0D, 1'b0});
        chk(16'(nk), 16'h0001);
        wb(8'h12);
        chk(16'(nk), 16'h0001);
        wb(8'h34);
        chk(16'(nk), 16'h0001);
        halt;
        chk(word, 16'h0FFF);
        chk(16'(upd_cnt - u0), 16'h0000);
    endtask

    // Broadcast loads two words; the second has only the top bit of
    // its low byte set, so a lost low-byte bit shows
    task automatic t_bcast;
        go;
        wb({7'h48, 1'b0});
        chk(16'(nk), 16'h0000);
        wb(8'h20);
        wb(8'h05);
        chk(word, 16'h2005);
        wb(8'h00);
        wb(8'h80);
        halt;
        chk(word, 16'h0080);
    endtask

    // High-speed entry, held across repeated starts, dropped by stop
    task automatic t_hs;
        go;
        wb(8'h09);
        chk(16'(nk), 16'h0001);
        chk(16'(hs_mode), 16'h0001);
        go;
        wb({7'h0C, 1'b0});
        chk(16'(nk), 16'h0000);
        wb(8'h01);
        wb(8'h23);
        go;
        chk(16'(hs_mode), 16'h0001);
        wb({7'h0C, 1'b1});
        rd(1'b0);
        chk(16'(rb), 16'h0001);
        rd(1'b1);
        chk(16'(rb), 16'h0023);
        halt;
        chk(16'(hs_mode), 16'h0000);
    endtask

    task automatic final_report;
        if (miscompares == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Whole run is near 182 us; over three times that means a hang
    initial begin
        #600000;
        miscompares++;
        final_report;
    end

    initial begin
        rst_n = 1'b0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk(word, 16'h0000);
        chk(16'(hs_mode), 16'h0000);
        t_write_read;
        t_foreign;
        t_bcast;
        t_hs;
        final_report;
    end
endmodule
